// [bench/esw_sw_model.sv]
/*
 * far-side model: a mechanical contact that chatters on every change.
 * assumes the bench sets the wanted level just after a rising edge.
 */
`timescale 1ns/100ps
module esw_sw_model (
	// clock
	input wire logic ref_clk,
	// wanted contact level
	input wire logic level,
	// line to the encoder
	output logic line
);
	int bounce = 0;
	logic last = 1'b1;
	initial line = 1'b1;
	// ***********************************
	// chatter for a few cycles, then settle
	// ***********************************
	always @(posedge ref_clk) begin
		if (level !== last) begin
			last <= level;
			bounce <= 4;
		end
		if (bounce > 0) begin
			line <= ~line;
			bounce <= bounce - 1;
		end else begin
			line <= last;
		end
	end
endmodule // esw_sw_model

// [bench/tb.sv]
/*
 * self-checking bench of the switch and led block: apb tasks, level model.
 * assumes short tick and debounce parameters, two bouncing contacts.
 */
`timescale 1ns/100ps
module tb import esw_pkg::*; ();
	logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'd61000;
	logic pready, pslverr, p_cmd = 1, t_cmd = 1, p_line, t_line, ta, eon, led1, led2;
	logic [2:0] active_program;
	logic [11:0] ctrl;
	int miscompares = 0, compares = 0, cyc = 0;
	always #5 ref_clk = ~ref_clk;
	esw_sw_model sw_p (.ref_clk(ref_clk), .level(p_cmd), .line(p_line));
	esw_sw_model sw_t (.ref_clk(ref_clk), .level(t_cmd), .line(t_line));
	esw_top #(.TICK_CYC(10), .DEB_TICKS(2)) uut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .prog_switch_in(p_line), .traffic_switch_in(t_line),
		.active_program(active_program), .traffic_announce_flag(ta),
		.other_network_one_traffic_flag(eon), .led1(led1), .led2(led2));
	// ***********************************
	// helpers
	// ***********************************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] mdl(input logic [11:0] c, input logic p, input logic t);
		logic [2:0] pr;
		pr = (c[2:0] == ESW_PROG_INPUT) ? (p ? ESW_PROG_ONE : ESW_PROG_TWO) : c[2:0];
		return {t, p, ~c[4] & c[5] & ~t, c[4] & ~c[6] & ~t, 1'b0, pr};
	endfunction
	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", 1, pready);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic setc(input logic [11:0] c);
		ctrl = c;
		apb(1'b1, ESW_CTRL_ADDR, {20'h0, c});
	endtask
	task automatic drv(input logic p, input logic t, input int n);
		@(posedge ref_clk);
		p_cmd <= p;
		t_cmd <= t;
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic chk_all(input logic p, input logic t);
		logic [7:0] e;
		e = mdl(ctrl, p, t);
		repeat (3) @(posedge ref_clk);
		chk("program", e[2:0], active_program);
		chk("ta", e[4], ta);
		chk("eon", e[5], eon);
		apb(1'b0, ESW_STATUS_ADDR, 32'h0);
		chk("status", e, rd);
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			finish_test();
		end
	end
	// ***********************************
	// scenarios
	// ***********************************
	initial begin
		logic [31:0] r;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		chk("led1", 0, led1);
		chk("led2", 1, led2);
		chk("program", ESW_PROG_DEF, active_program);
		apb(1'b0, ESW_CTRL_ADDR, 32'h0);
		chk("ctrl", ESW_CTRL_RST, rd);
		apb(1'b0, 8'h0c, 32'h0);
		chk("unmapped", 1, err);
		apb(1'b1, ESW_STATUS_ADDR, 32'hff);
		chk("ro write", 1, err);
		setc(12'h000);
		chk_all(1'b1, 1'b1);
		drv(1'b0, 1'b1, 60);
		chk_all(1'b0, 1'b1);
		for (int i = 0; i < 4; i++) begin
			r = xs() % 32'd6 + 32'd1;
			setc(r[11:0]);
			chk_all(1'b0, 1'b1);
		end
		apb(1'b1, ESW_CTRL_ADDR, 32'h7);
		chk_all(1'b0, 1'b1);
		for (int k = 0; k < 3; k++) begin
			setc(k == 0 ? 12'h010 : (k == 1 ? 12'h060 : 12'h000));
			drv(1'b1, 1'b0, 60);
			chk_all(1'b1, 1'b0);
			drv(1'b1, 1'b1, 60);
			chk_all(1'b1, 1'b1);
		end
		r = xs();
		apb(1'b1, ESW_TMOUT_ADDR, r);
		apb(1'b0, ESW_TMOUT_ADDR, 32'h0);
		chk("tmout", r[15:0], rd[15:0]);
		apb(1'b1, ESW_TMOUT_ADDR, 32'h5);
		setc(12'h050);
		drv(1'b1, 1'b0, 40);
		chk("ta", 1, ta);
		repeat (60) @(posedge ref_clk);
		chk("ta", 0, ta);
		drv(1'b1, 1'b1, 60);
		apb(1'b1, ESW_TMOUT_ADDR, 32'h14);
		for (int k = 0; k < 2; k++) begin
			setc(k == 1 ? 12'h0d0 : 12'h050);
			drv(1'b1, 1'b0, 40);
			chk("ta", 1, ta);
			drv(1'b1, 1'b1, 50);
			chk("ta", k == 0, ta);
			repeat (250) @(posedge ref_clk);
		end
		for (int k = 0; k < 16; k++) begin
			setc({k[3:0], 8'h00});
			repeat (2) @(posedge ref_clk);
			chk("led1", k[0] ? 0 : (k[1] ? 1 : k[2]), led1);
			chk("led2", k[0] ? 1 : (k[1] ? 0 : k[3]), led2);
		end
		finish_test();
	end
endmodule // tb

// [include/esw_pkg.sv]
/*
 * constants for the encoder switch and led block: register map, field layouts,
 * reset values and timing.
 * assumes a 100 MHz system clock and an apb master with 32-bit data.
 */
package esw_pkg;
	// ***********************************
	// register offsets (byte addresses)
	// ***********************************
	localparam logic [7:0] ESW_CTRL_ADDR = 8'h00;
	localparam logic [7:0] ESW_TMOUT_ADDR = 8'h04;
	localparam logic [7:0] ESW_STATUS_ADDR = 8'h08;
	// ***********************************
	// control fields
	// ***********************************
	localparam int ESW_PROG_LSB = 0;
	localparam int ESW_PROG_W = 3;
	localparam int ESW_TP_BIT = 4;
	localparam int ESW_OTHER_NETWORK_ONE_ENABLE_BIT = 5;
	localparam int ESW_EDGE_BIT = 6;
	localparam int ESW_RISE_BIT = 7;
	localparam int ESW_INIT_BIT = 8;
	localparam int ESW_FWUP_BIT = 9;
	localparam int ESW_PORT_BIT = 10;
	localparam int ESW_PILOT_BIT = 11;
	localparam logic [2:0] ESW_PROG_INPUT = 3'h0;
	localparam logic [2:0] ESW_PROG_DEF = 3'h1;
	localparam logic [2:0] ESW_PROG_ONE = 3'h1;
	localparam logic [2:0] ESW_PROG_TWO = 3'h2;
	localparam logic [2:0] ESW_PROG_MAX = 3'h6;
	localparam logic [11:0] ESW_CTRL_RST = 12'h101;
	// ***********************************
	// status fields
	// ***********************************
	localparam int ESW_ST_PROG_LSB = 0;
	localparam int ESW_ST_TA_BIT = 4;
	localparam int ESW_ST_EON_BIT = 5;
	localparam int ESW_ST_PSW_BIT = 6;
	localparam int ESW_ST_TSW_BIT = 7;
	// ***********************************
	// timing
	// ***********************************
	localparam int ESW_CLK_MHZ = 100;
	localparam int ESW_TICK_US = 1000;
	localparam int ESW_TICK_CYC = ESW_TICK_US * ESW_CLK_MHZ;
	localparam int ESW_DEB_MS = 10;
	localparam logic [15:0] ESW_TMOUT_RST = 16'h001e;
endpackage

// [logic/esw_top.sv]
/*
 * front-panel switch inputs and status leds of the data encoder, with an apb
 * register slave.
 * assumes switch inputs synchronous in nature only after the local synchroniser;
 * one clock, no interrupts.
 */
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module esw_top import esw_pkg::*; #(
	parameter int TICK_CYC = ESW_TICK_CYC,
	parameter int DEB_TICKS = ESW_DEB_MS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// switch inputs
	input wire logic prog_switch_in,
	input wire logic traffic_switch_in,
	// results
	output logic [2:0] active_program,
	output logic traffic_announce_flag,
	output logic other_network_one_traffic_flag,
	output logic led1,
	output logic led2
);
	typedef enum logic [2:0] {
		ESW_IDLE = 3'h1,
		ESW_HELD = 3'h2,
		ESW_WAIT = 3'h4
	} esw_ta_t;

	typedef struct packed {
		logic [11:0] ctrl;
		logic [15:0] tmout;
		logic [1:0] p_sync;
		logic [1:0] t_sync;
		logic [7:0] p_deb;
		logic [7:0] t_deb;
		logic p_clean;
		logic t_clean;
		logic [31:0] tick_cnt;
		logic tick;
		logic [15:0] ta_cnt;
		esw_ta_t ta_st;
		logic ta;
		logic eon;
		logic [2:0] prog;
		logic led1;
		logic led2;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} esw_state_t;

	esw_state_t s;
	esw_state_t next_s;

	function automatic logic [7:0] esw_deb_step(input logic [7:0] cnt, input logic raw, input logic clean,
			input logic tick);
		if (raw == clean)
			return 8'h00;
		else if (tick)
			return cnt + 8'h01;
		else
			return cnt;
	endfunction

	// ***********************************
	// next state
	// ***********************************
	always_comb begin
		logic fall;
		logic rise;
		logic p_new;
		logic t_new;
		logic acc;
		next_s = s;
		fall = 1'b0;
		rise = 1'b0;
		// access taken once; pready blocks a second take
		acc = psel && penable && !s.pready;
		next_s.p_sync = {s.p_sync[0], prog_switch_in};
		next_s.t_sync = {s.t_sync[0], traffic_switch_in};
		// shared ms tick for debounce and timeout
		next_s.tick = (s.tick_cnt == 32'(TICK_CYC - 1));
		next_s.tick_cnt = next_s.tick ? 32'h0 : s.tick_cnt + 32'h1;
		next_s.p_deb = esw_deb_step(s.p_deb, s.p_sync[1], s.p_clean, s.tick);
		next_s.t_deb = esw_deb_step(s.t_deb, s.t_sync[1], s.t_clean, s.tick);
		p_new = s.p_clean;
		t_new = s.t_clean;
		if (s.p_deb == 8'(DEB_TICKS)) begin
			p_new = s.p_sync[1];
			next_s.p_deb = 8'h00;
		end
		if (s.t_deb == 8'(DEB_TICKS)) begin
			t_new = s.t_sync[1];
			next_s.t_deb = 8'h00;
		end
		fall = s.t_clean && !t_new;
		rise = !s.t_clean && t_new;
		next_s.p_clean = p_new;
		next_s.t_clean = t_new;
		// program set
		if (s.ctrl[ESW_PROG_LSB +: ESW_PROG_W] == ESW_PROG_INPUT)
			next_s.prog = p_new ? ESW_PROG_ONE : ESW_PROG_TWO;
		else
			next_s.prog = s.ctrl[ESW_PROG_LSB +: ESW_PROG_W];
		// traffic switch
		if (s.ctrl[ESW_TP_BIT]) begin
			next_s.eon = s.eon;
			if (!s.ctrl[ESW_EDGE_BIT]) begin
				next_s.ta = !t_new;
				next_s.ta_st = ESW_IDLE;
			end else begin
				unique case (s.ta_st)
					ESW_IDLE: begin
						if (fall) begin
							next_s.ta = 1'b1;
							next_s.ta_cnt = 16'h0;
							next_s.ta_st = ESW_HELD;
						end else
							next_s.ta = 1'b0;
					end
					ESW_HELD: begin
						if (rise && s.ctrl[ESW_RISE_BIT]) begin
							next_s.ta = 1'b0;
							next_s.ta_st = ESW_IDLE;
						end else if (s.tick) begin
							next_s.ta_cnt = s.ta_cnt + 16'h1;
							if (s.ta_cnt + 16'h1 >= s.tmout) begin
								next_s.ta = 1'b0;
								next_s.ta_st = ESW_WAIT;
							end
						end
					end
					// no rearm until the switch is released
					ESW_WAIT: begin
						next_s.ta = 1'b0;
						if (t_new)
							next_s.ta_st = ESW_IDLE;
					end
					default: next_s.ta_st = ESW_IDLE;
				endcase
			end
		end else if (s.ctrl[ESW_OTHER_NETWORK_ONE_ENABLE_BIT]) begin
			next_s.eon = !t_new;
			next_s.ta_st = ESW_IDLE;
		end else
			next_s.ta_st = ESW_IDLE;
		// leds
		if (s.ctrl[ESW_INIT_BIT]) begin
			next_s.led1 = 1'b0;
			next_s.led2 = 1'b1;
		end else if (s.ctrl[ESW_FWUP_BIT]) begin
			next_s.led1 = 1'b1;
			next_s.led2 = 1'b0;
		end else begin
			next_s.led1 = s.ctrl[ESW_PORT_BIT];
			next_s.led2 = s.ctrl[ESW_PILOT_BIT];
		end
		// apb
		next_s.pready = acc;
		next_s.pslverr = 1'b0;
		if (acc) begin
			unique case (paddr)
				ESW_CTRL_ADDR: begin
					next_s.prdata = {20'h0, s.ctrl};
					if (pwrite) begin
						next_s.ctrl = pwdata[11:0];
						// out-of-range set keeps the old selection
						if (pwdata[ESW_PROG_LSB +: ESW_PROG_W] > ESW_PROG_MAX)
							next_s.ctrl[ESW_PROG_LSB +: ESW_PROG_W] = s.ctrl[ESW_PROG_LSB +: ESW_PROG_W];
					end
				end
				ESW_TMOUT_ADDR: begin
					next_s.prdata = {16'h0, s.tmout};
					if (pwrite)
						next_s.tmout = pwdata[15:0];
				end
				ESW_STATUS_ADDR: begin
					next_s.prdata = {24'h0, s.t_clean, s.p_clean, s.eon, s.ta, 1'b0, s.prog};
					next_s.pslverr = pwrite;
				end
				default: begin
					next_s.prdata = 32'h0;
					next_s.pslverr = 1'b1;
				end
			endcase
		end else
			next_s.prdata = 32'h0;
	end

	// ***********************************
	// state register
	// ***********************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.ctrl <= ESW_CTRL_RST;
			s.tmout <= ESW_TMOUT_RST;
			s.p_sync <= 2'h3;
			s.t_sync <= 2'h3;
			s.p_clean <= 1'b1;
			s.t_clean <= 1'b1;
			s.ta_st <= ESW_IDLE;
			s.prog <= ESW_PROG_DEF;
			s.led2 <= 1'b1;
		end else
			s <= next_s;
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign active_program = s.prog;
	assign traffic_announce_flag = s.ta;
	assign other_network_one_traffic_flag = s.eon;
	assign led1 = s.led1;
	assign led2 = s.led2;

	// ***********************************
	// checks
	// ***********************************
	sequence esw_fall_seen;
		s.t_clean ##1 !s.t_clean;
	endsequence

	a_prog_fixed_set: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.ctrl[ESW_PROG_LSB +: ESW_PROG_W] != ESW_PROG_INPUT |=> s.prog == $past(s.ctrl[ESW_PROG_LSB +: ESW_PROG_W]))
		else $error("fixed program set not applied");
	a_prog_input_high: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.ctrl[ESW_PROG_LSB +: ESW_PROG_W] == ESW_PROG_INPUT |=> !s.p_clean || s.prog == ESW_PROG_ONE)
		else $error("high input did not select set one");
	a_prog_input_low: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.ctrl[ESW_PROG_LSB +: ESW_PROG_W] == ESW_PROG_INPUT |=> s.p_clean || s.prog == ESW_PROG_TWO)
		else $error("low input did not select set two");
	a_ta_level_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.ctrl[ESW_TP_BIT] && !s.ctrl[ESW_EDGE_BIT] && $stable(s.t_clean) && $stable(s.ctrl)
		|=> s.ta == !s.t_clean)
		else $error("level mode flag wrong");
	a_ta_edge_set: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.ctrl[ESW_TP_BIT] && s.ctrl[ESW_EDGE_BIT] && $stable(s.ctrl) && s.ta_st == ESW_IDLE
		##0 esw_fall_seen |-> s.ta)
		else $error("falling edge did not set flag");
	a_ta_rise_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.ctrl[ESW_TP_BIT] && s.ctrl[ESW_EDGE_BIT] && s.ctrl[ESW_RISE_BIT] && s.ta_st == ESW_HELD
		&& !s.t_clean ##1 s.t_clean && $stable(s.ctrl) |-> !s.ta)
		else $error("rising edge did not clear flag");
	a_eon_level: assert property (@(posedge ref_clk) disable iff (!resetn)
		!s.ctrl[ESW_TP_BIT] && s.ctrl[ESW_OTHER_NETWORK_ONE_ENABLE_BIT] && $stable(s.t_clean) && $stable(s.ctrl)
		|=> s.eon == !s.t_clean)
		else $error("other-network flag not level");
	a_switch_off: assert property (@(posedge ref_clk) disable iff (!resetn)
		!s.ctrl[ESW_TP_BIT] && !s.ctrl[ESW_OTHER_NETWORK_ONE_ENABLE_BIT] |=> $stable(s.ta) && $stable(s.eon))
		else $error("disabled switch changed a flag");
	a_led_init: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.ctrl[ESW_INIT_BIT] |=> !s.led1 && s.led2)
		else $error("init led pattern wrong");
	a_led_port: assert property (@(posedge ref_clk) disable iff (!resetn)
		!s.ctrl[ESW_INIT_BIT] && !s.ctrl[ESW_FWUP_BIT] |=> s.led1 == $past(s.ctrl[ESW_PORT_BIT]))
		else $error("activity led wrong");
	a_led_pilot: assert property (@(posedge ref_clk) disable iff (!resetn)
		!s.ctrl[ESW_INIT_BIT] && !s.ctrl[ESW_FWUP_BIT] |=> s.led2 == $past(s.ctrl[ESW_PILOT_BIT]))
		else $error("pilot led wrong");
	a_deb_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.t_sync[1] == s.t_clean |=> s.t_clean == $past(s.t_clean))
		else $error("clean input moved without cause");

	// ***********************************
	// checks: traffic modes and target, update leds, program range
	// ***********************************
	sequence esw_rise_seen;
		!s.t_clean ##1 s.t_clean;
	endsequence

	a_rise_ignored: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.ctrl[ESW_TP_BIT] && s.ctrl[ESW_EDGE_BIT] && !s.ctrl[ESW_RISE_BIT] && s.ta_st == ESW_HELD
		&& !s.tick ##0 esw_rise_seen |-> s.ta)
		else $error("rising edge cleared flag while disabled");
	a_level_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.ctrl[ESW_TP_BIT] && !s.ctrl[ESW_EDGE_BIT] |=> s.ta_st == ESW_IDLE)
		else $error("level mode left edge state busy");
	a_held_lit: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.ta_st == ESW_HELD |-> s.ta)
		else $error("flag dark while held");
	a_wait_dark: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.ta_st == ESW_WAIT |-> !s.ta)
		else $error("flag lit after timeout");
	a_eon_kept: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.ctrl[ESW_TP_BIT] |=> $stable(s.eon))
		else $error("other-network flag moved while local target");
	a_ta_kept: assert property (@(posedge ref_clk) disable iff (!resetn)
		!s.ctrl[ESW_TP_BIT] && s.ctrl[ESW_OTHER_NETWORK_ONE_ENABLE_BIT] |=> $stable(s.ta))
		else $error("local flag moved while other-network target");
	a_led_fwup: assert property (@(posedge ref_clk) disable iff (!resetn)
		!s.ctrl[ESW_INIT_BIT] && s.ctrl[ESW_FWUP_BIT] |=> s.led1 && !s.led2)
		else $error("update led pattern wrong");
	a_prog_range: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.prog >= ESW_PROG_ONE && s.prog <= ESW_PROG_MAX)
		else $error("program set out of range");

	// ***********************************
	// checks: inputs and bus
	// ***********************************
	a_sync_prog: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.p_sync[1] == $past(prog_switch_in, 2))
		else $error("program input not two-stage synchronised");
	a_sync_traffic: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.t_sync[1] == $past(traffic_switch_in, 2))
		else $error("traffic input not two-stage synchronised");
	a_deb_hold_prog: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.p_sync[1] == s.p_clean |=> s.p_clean == $past(s.p_clean))
		else $error("clean program input moved without cause");
	a_deb_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.t_sync[1] == s.t_clean |=> s.t_deb == 8'h00)
		else $error("debounce count kept while input agrees");
	a_ready_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.pready |=> !s.pready)
		else $error("pready longer than one cycle");
	a_err_ready: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.pslverr |-> s.pready)
		else $error("pslverr without pready");
	a_tick_single: assert property (@(posedge ref_clk) disable iff (!resetn)
		s.tick |=> !s.tick)
		else $error("tick longer than one cycle");
endmodule // esw_top
